/* rtl/auto_cycle_start.sv */
/*
  Cycle start qualification, feed hold, auxiliary finish handshake (normal and
  fast toggle), in-position gating, feedrate override decode and wait flags.
  Assumes the signal bytes arrive from outside the clock domain; the sequencer
  supplies function requests and motion/dwell/spindle status as single-clock pulses or levels.
*/
// What this block does
// - Code 000 is manual entry; 001 memory or remote by remote flag.
// - Cycle go high while pressed; launch only on its falling edge.
// - Hold input bit 5 active low; zero places operation in feed hold.
// - Config bit 7 selects normal finish line or fast toggle handshake.
// - Normal handshake completes when finish bit 3 falls; then next block.
// - Fast handshake completes when finish equals strobe; toggle to request.
// - Milling strobes bits 0,2,3,7; second finish bit 7 or 4.
// - Turning strobes and finishes in bits 0,2,3,4.
// - Second and third misc strobes bits 4,5, enabled by multi-misc bit.
// - Hold next block until position error within in-position width.
// - Primary override active low, inverted value is percent, zero means 0%.
// - Fine override same encoding, applied as further scaling.
// - Readable wait flags 000 to 015 for each waiting cause.
// - Launch lock bit 1 high blocks automatic start.
`timescale 1ns/1ps
module auto_cycle_start
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  mode_select_input,
  input  wire logic [7:0]  cycle_start_input,
  input  wire logic [7:0]  feed_hold_input,
  input  wire logic [7:0]  aux_finish_inputs,
  input  wire logic [7:0]  aux_fast_finish_inputs,
  input  wire logic [7:0]  feed_override_primary,
  input  wire logic [7:0]  feed_override_fine,
  input  wire logic [7:0]  aux_interface_config,
  input  wire logic [7:0]  multi_misc_config,
  input  wire logic        turning_variant,
  input  wire logic        fine_override_fitted,
  input  wire logic [5:0]  func_request,
  input  wire logic        positioning_done,
  input  wire logic [15:0] position_error,
  input  wire logic [15:0] inpos_width,
  input  wire logic        block_request,
  input  wire logic [15:0] other_wait_status,
  output logic             auto_running,
  output logic             feed_hold_active,
  output logic             block_advance,
  output logic [2:0]       mode_decoded,
  output logic [7:0]       aux_strobe_outputs,
  output logic [7:0]       extra_m_strobe_outputs,
  output logic [15:0]      feed_scale_pct,
  output logic [15:0]      sequencer_diag_view
);
  typedef enum logic [1:0] {MODE_NONE, MODE_MEM, MODE_RMT, MODE_MDI} op_mode_e;
  typedef enum {ST_IDLE, ST_RUN, ST_WAIT_AUX, ST_WAIT_INPOS} run_state_e;

  // =====================================================
  // Input synchronisers
  logic [7:0] mode_m_ff;
  logic [7:0] mode_s_ff;
  logic [7:0] go_m_ff;
  logic [7:0] go_s_ff;
  logic [7:0] hold_m_ff;
  logic [7:0] hold_s_ff;
  logic [7:0] fin_m_ff;
  logic [7:0] fin_s_ff;
  logic [7:0] ffin_m_ff;
  logic [7:0] ffin_s_ff;
  logic [7:0] ovp_m_ff;
  logic [7:0] ovp_s_ff;
  logic [7:0] ovf_m_ff;
  logic [7:0] ovf_s_ff;
  logic       go_prev_ff;
  // Two stages per byte; only the second stage feeds logic
  always_ff @(posedge sys_clk)
  begin
    mode_m_ff <= mode_select_input;
    mode_s_ff <= mode_m_ff;
    go_m_ff   <= cycle_start_input;
    go_s_ff   <= go_m_ff;
    hold_m_ff <= feed_hold_input;
    hold_s_ff <= hold_m_ff;
    fin_m_ff  <= aux_finish_inputs;
    fin_s_ff  <= fin_m_ff;
    ffin_m_ff <= aux_fast_finish_inputs;
    ffin_s_ff <= ffin_m_ff;
    ovp_m_ff  <= feed_override_primary;
    ovp_s_ff  <= ovp_m_ff;
    ovf_m_ff  <= feed_override_fine;
    ovf_s_ff  <= ovf_m_ff;
  end

  // =====================================================
  // Mode decode and start qualification
  function automatic op_mode_e decode_mode(input logic [7:0] b);
    logic [2:0] code;
    code = b[auto_start_pkg::MODE_HI:0];
    if (code == auto_start_pkg::MODE_MANUAL_ENTRY)
      decode_mode = MODE_MDI;
    else if (code == auto_start_pkg::MODE_MEMORY)
      decode_mode = b[auto_start_pkg::REMOTE_BIT] ? MODE_RMT : MODE_MEM;
    else
      decode_mode = MODE_NONE;
  endfunction

  op_mode_e   cur_mode;
  wire        go_now      = go_s_ff[auto_start_pkg::CYCLE_GO_BIT];
  wire        go_fall     = go_prev_ff & ~go_now;
  wire        hold_req    = ~hold_s_ff[auto_start_pkg::HOLD_N_BIT];
  wire        launch_lock = go_s_ff[auto_start_pkg::LAUNCH_LOCK_BIT];
  wire        mode_ok;
  wire        start_ok;
  assign cur_mode = decode_mode(mode_s_ff);
  assign mode_ok  = (cur_mode != MODE_NONE);
  assign start_ok = go_fall & mode_ok & ~hold_req & ~launch_lock;

  // =====================================================
  // Auxiliary handshake
  wire        fast_sel   = aux_interface_config[auto_start_pkg::FAST_SEL_BIT];
  wire        multi_en   = multi_misc_config[auto_start_pkg::MULTI_MISC_BIT];
  logic       norm_prev_ff;
  wire        norm_fin   = fin_s_ff[auto_start_pkg::AUX_DONE_BIT];
  wire        norm_fall  = norm_prev_ff & ~norm_fin;
  logic [5:0] req_tog_ff, pend_ff;
  logic [5:0] fast_fin;
  logic [5:0] fast_done;
  // Function order: misc, speed, tool, second aux, misc2, misc3
  assign fast_fin[0] = ffin_s_ff[auto_start_pkg::MISC_BIT];
  assign fast_fin[1] = ffin_s_ff[auto_start_pkg::SPEED_BIT];
  assign fast_fin[2] = ffin_s_ff[auto_start_pkg::TOOL_BIT];
  assign fast_fin[3] = turning_variant ? ffin_s_ff[auto_start_pkg::SECOND_TURN_BIT]
                                       : (ffin_s_ff[auto_start_pkg::SECOND_MILL_BIT]
                                          | ffin_s_ff[auto_start_pkg::SECOND_TURN_BIT]) ^ 1'b0;
  assign fast_fin[4] = fin_s_ff[auto_start_pkg::MISC2_BIT];
  assign fast_fin[5] = fin_s_ff[auto_start_pkg::MISC3_BIT];
  genvar gi;
  generate
    for (gi = 0; gi < auto_start_pkg::NUM_FUNCS; gi++)
    begin : g_fast
      assign fast_done[gi] = (fast_fin[gi] == req_tog_ff[gi]);
    end
  endgenerate
  wire [5:0] req_allowed = {{2{multi_en}}, 4'hF};
  wire [5:0] new_req     = func_request & req_allowed;
  wire       aux_clear   = fast_sel ? ((pend_ff & ~fast_done) == 6'h00) : norm_fall;

  // =====================================================
  // Run state
  run_state_e state_ff, nxt_state;
  wire        inpos_ok = (position_error <= inpos_width);
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE:       if (start_ok) nxt_state = ST_RUN;
      ST_RUN:
        if (hold_req)                nxt_state = ST_IDLE;
        else if (new_req != 6'h00)   nxt_state = ST_WAIT_AUX;
        else if (positioning_done)   nxt_state = ST_WAIT_INPOS;
      ST_WAIT_AUX:   if (aux_clear) nxt_state = ST_RUN;
      ST_WAIT_INPOS: if (inpos_ok)  nxt_state = ST_RUN;
    endcase
  end

  // =====================================================
  // Override decode
  wire [7:0]  ovp_pct  = (ovp_s_ff == auto_start_pkg::OVERRIDE_ZERO) ? 8'h00 : ~ovp_s_ff;
  wire [7:0]  ovf_pct  = (ovf_s_ff == auto_start_pkg::OVERRIDE_ZERO) ? 8'h00 : ~ovf_s_ff;
  wire [15:0] prod     = 16'(ovp_pct) * 16'(ovf_pct);
  wire [15:0] nxt_scale = fine_override_fitted ? 16'(prod / 16'h0064) : {8'h00, ovp_pct};

  // =====================================================
  // Wait flags
  logic [15:0] nxt_wait;
  always_comb
  begin
    nxt_wait = other_wait_status;
    nxt_wait[auto_start_pkg::WAIT_FINISH]    = (state_ff == ST_WAIT_AUX);
    nxt_wait[auto_start_pkg::WAIT_INPOS]     = (state_ff == ST_WAIT_INPOS);
    nxt_wait[auto_start_pkg::WAIT_OVR_ZERO]  = (nxt_scale == 16'h0000) & (state_ff != ST_IDLE);
    nxt_wait[auto_start_pkg::WAIT_INTERLOCK] = launch_lock;
  end

  // =====================================================
  // Strobe byte images
  logic [7:0] nxt_aux_strobe;
  logic [7:0] nxt_extra_strobe;
  always_comb
  begin
    nxt_aux_strobe                            = auto_start_pkg::BYTE_RESET_VAL;
    nxt_aux_strobe[auto_start_pkg::MISC_BIT]  = req_tog_ff[0];
    nxt_aux_strobe[auto_start_pkg::SPEED_BIT] = req_tog_ff[1];
    nxt_aux_strobe[auto_start_pkg::TOOL_BIT]  = req_tog_ff[2];
    if (turning_variant)
      nxt_aux_strobe[auto_start_pkg::SECOND_TURN_BIT] = req_tog_ff[3];
    else
      nxt_aux_strobe[auto_start_pkg::SECOND_MILL_BIT] = req_tog_ff[3];
  end

  always_comb
  begin
    nxt_extra_strobe                            = auto_start_pkg::BYTE_RESET_VAL;
    nxt_extra_strobe[auto_start_pkg::MISC2_BIT] = req_tog_ff[4] & multi_en;
    nxt_extra_strobe[auto_start_pkg::MISC3_BIT] = req_tog_ff[5] & multi_en;
  end

  // =====================================================
  // Registers
  wire any_req     = (new_req != 6'h00);
  wire nxt_running = (nxt_state != ST_IDLE);
  // Pulse only on return to run from a wait, not on launch
  wire nxt_advance = (nxt_state == ST_RUN) & (state_ff != ST_RUN) & (state_ff != ST_IDLE);

  // Edge history for release and finish detectors
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      go_prev_ff   <= 1'b0;
      norm_prev_ff <= 1'b0;
    end
    else
    begin
      go_prev_ff   <= go_now;
      norm_prev_ff <= norm_fin;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Requests only taken while running and not waiting
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      req_tog_ff <= 6'h00;
      pend_ff    <= 6'h00;
    end
    else if (state_ff == ST_RUN && any_req)
    begin
      req_tog_ff <= req_tog_ff ^ new_req;
      pend_ff    <= new_req;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      auto_running     <= 1'b0;
      feed_hold_active <= 1'b0;
      block_advance    <= 1'b0;
      mode_decoded     <= 3'h0;
    end
    else
    begin
      auto_running     <= nxt_running;
      feed_hold_active <= hold_req;
      block_advance    <= nxt_advance;
      mode_decoded     <= {1'b0, cur_mode};
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      aux_strobe_outputs     <= auto_start_pkg::BYTE_RESET_VAL;
      extra_m_strobe_outputs <= auto_start_pkg::BYTE_RESET_VAL;
    end
    else
    begin
      aux_strobe_outputs     <= nxt_aux_strobe;
      extra_m_strobe_outputs <= nxt_extra_strobe;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      feed_scale_pct      <= 16'h0000;
      sequencer_diag_view <= auto_start_pkg::WAIT_RESET_VAL;
    end
    else
    begin
      feed_scale_pct      <= nxt_scale;
      sequencer_diag_view <= nxt_wait;
    end
  end

  // =====================================================
  // Checks
  chk_start_edge: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_ff == ST_IDLE && nxt_state == ST_RUN) |-> (go_prev_ff && !go_now && !hold_req && !launch_lock))
    else $error("start without qualified release");
  chk_hold_stop: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_ff == ST_RUN && hold_req) |=> state_ff == ST_IDLE)
    else $error("hold did not stop run");
  chk_norm_fin: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_ff == ST_WAIT_AUX && !fast_sel && !norm_fall) |=> state_ff == ST_WAIT_AUX)
    else $error("aux wait left without finish fall");
  chk_inpos_wait: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_ff == ST_WAIT_INPOS && !inpos_ok) |=> state_ff == ST_WAIT_INPOS)
    else $error("in-position wait left early");
  chk_override_zero: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ovp_s_ff == 8'h00 || ovp_s_ff == 8'hFF) |=> feed_scale_pct == 16'h0000)
    else $error("override zero not decoded");
  chk_mode_remote: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mode_s_ff[2:0] == 3'h1 && mode_s_ff[5]) |=> mode_decoded == 3'(MODE_RMT))
    else $error("remote mode not decoded");
  chk_multi_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !multi_en |=> extra_m_strobe_outputs == 8'h00)
    else $error("extra strobe while disabled");
  chk_wait_flag: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state_ff == ST_WAIT_AUX) |=> sequencer_diag_view[0])
    else $error("finish wait flag missing");
endmodule // auto_cycle_start

/* rtl/auto_start_pkg.sv */
/*
  Constants for the automatic cycle start and auxiliary handshake block.
  Assumes the sequence controller drives whole signal bytes on sys_clk edges or from pins.
*/
package auto_start_pkg;
  // Mode select byte
  localparam int REMOTE_BIT      = 5;
  localparam int MODE_HI         = 2;
  localparam logic [2:0] MODE_MANUAL_ENTRY = 3'h0;
  localparam logic [2:0] MODE_MEMORY       = 3'h1;
  // Signal bytes
  localparam int CYCLE_GO_BIT    = 2;
  localparam int LAUNCH_LOCK_BIT = 1;
  localparam int HOLD_N_BIT      = 5;
  localparam int AUX_DONE_BIT    = 3;
  localparam int FAST_SEL_BIT    = 7;
  localparam int MULTI_MISC_BIT  = 7;
  // Strobe bit positions
  localparam int MISC_BIT        = 0;
  localparam int SPEED_BIT       = 2;
  localparam int TOOL_BIT        = 3;
  localparam int SECOND_MILL_BIT = 7;
  localparam int SECOND_TURN_BIT = 4;
  localparam int MISC2_BIT       = 4;
  localparam int MISC3_BIT       = 5;
  localparam int NUM_FUNCS       = 6;
  // Override
  localparam logic [7:0] OVERRIDE_ZERO = 8'h00;
  // Wait flag numbers
  localparam int WAIT_FINISH     = 0;
  localparam int WAIT_MOTION     = 1;
  localparam int WAIT_DWELL      = 2;
  localparam int WAIT_INPOS      = 3;
  localparam int WAIT_OVR_ZERO   = 4;
  localparam int WAIT_INTERLOCK  = 5;
  localparam int WAIT_SPINDLE    = 6;
  localparam int WAIT_PUNCH      = 10;
  localparam int WAIT_READ       = 11;
  localparam int WAIT_CLAMP      = 12;
  localparam int WAIT_JOG_ZERO   = 13;
  localparam int WAIT_RESET      = 14;
  localparam int WAIT_SEARCH     = 15;
  localparam logic [15:0] WAIT_RESET_VAL = 16'h0000;
  localparam logic [7:0]  BYTE_RESET_VAL = 8'h00;
  localparam logic [7:0]  HOLD_IDLE_VAL  = 8'h20;
endpackage

/* verification/seq_ctrl_model.sv */
/*
  Sequence controller model: answers the finish handshake of the cycle start block.
  Assumes strobe bytes change on sys_clk edges; answers after lag cycles.
*/
`timescale 1ns/1ps
module seq_ctrl_model
(
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       fast_sel,
  input  wire logic       turning,
  input  wire logic [3:0] lag,
  input  wire logic [7:0] aux_strobe_outputs,
  input  wire logic [7:0] extra_m_strobe_outputs,
  output logic      [7:0] aux_finish_inputs,
  output logic      [7:0] aux_fast_finish_inputs
);
  logic [7:0] s;
  logic [7:0] echo;
  logic [7:0] seen_ff;
  logic [7:0] seen_x_ff;
  int         wait_cnt;
  assign s    = aux_strobe_outputs;
  assign echo = turning ? {3'b000, s[4], s[3], s[2], 1'b0, s[0]} : {s[7], 3'b000, s[3], s[2], 1'b0, s[0]};
  // ==========================================================
  // Finish answer
  always @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      seen_ff <= 8'h00;
      seen_x_ff <= 8'h00;
      wait_cnt <= 0;
      aux_finish_inputs <= 8'h00;
      aux_fast_finish_inputs <= 8'h00;
    end
    else if (s != seen_ff || extra_m_strobe_outputs != seen_x_ff)
    begin
      if (wait_cnt < int'(lag))
        wait_cnt <= wait_cnt + 1;
      else
      begin
        wait_cnt <= 0;
        seen_ff <= s;
        seen_x_ff <= extra_m_strobe_outputs;
        if (fast_sel)
        begin
          aux_fast_finish_inputs <= echo;
          aux_finish_inputs[5:4] <= extra_m_strobe_outputs[5:4];
        end
        else
          aux_finish_inputs[3] <= 1'b1;
      end
    end
    else if (!fast_sel && aux_finish_inputs[3])
      aux_finish_inputs[3] <= 1'b0;
  end
endmodule // seq_ctrl_model

/* verification/tb_auto_cycle_start.sv */
/*
  Self-checking bench for the automatic cycle start block.
  Assumes one 100 MHz clock and the sequence controller model on the finish inputs.
*/
`timescale 1ns/1ps
module tb_auto_cycle_start;
  logic        sys_clk = 0, sys_rst = 1, turning_variant = 0, fine_override_fitted = 0, positioning_done = 0;
  logic [7:0]  mode_select_input = 0, cycle_start_input = 0, feed_hold_input = 8'h20;
  logic [7:0]  feed_override_primary = 8'h9b, feed_override_fine = 8'h9b, aux_interface_config = 8'h80;
  logic [7:0]  multi_misc_config = 0, aux_finish_inputs, aux_fast_finish_inputs;
  logic [5:0]  func_request = 0;
  logic [15:0] position_error = 0, inpos_width = 16'h0014, other_wait_status = 0;
  logic        auto_running, feed_hold_active, block_advance;
  logic [2:0]  mode_decoded;
  logic [7:0]  aux_strobe_outputs, extra_m_strobe_outputs;
  logic [15:0] feed_scale_pct, sequencer_diag_view;
  logic [3:0]  lag = 0;
  logic [7:0]  p, f;
  logic [7:0]  modes [6] = '{8'h00, 8'h20, 8'h01, 8'h21, 8'h02, 8'h27};
  int          n_fail = 0, checks = 0;
  bit          adv;
  always #5 sys_clk = ~sys_clk;
  auto_cycle_start auto_cycle_start_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .mode_select_input(mode_select_input),
    .cycle_start_input(cycle_start_input), .feed_hold_input(feed_hold_input), .aux_finish_inputs(aux_finish_inputs),
    .aux_fast_finish_inputs(aux_fast_finish_inputs), .feed_override_primary(feed_override_primary),
    .feed_override_fine(feed_override_fine), .aux_interface_config(aux_interface_config),
    .multi_misc_config(multi_misc_config), .turning_variant(turning_variant), .fine_override_fitted(fine_override_fitted),
    .func_request(func_request), .positioning_done(positioning_done), .position_error(position_error),
    .inpos_width(inpos_width), .block_request(1'b0), .other_wait_status(other_wait_status), .auto_running(auto_running),
    .feed_hold_active(feed_hold_active), .block_advance(block_advance), .mode_decoded(mode_decoded),
    .aux_strobe_outputs(aux_strobe_outputs), .extra_m_strobe_outputs(extra_m_strobe_outputs),
    .feed_scale_pct(feed_scale_pct), .sequencer_diag_view(sequencer_diag_view));
  seq_ctrl_model seq_ctrl_model_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .fast_sel(aux_interface_config[7]),
    .turning(turning_variant), .lag(lag), .aux_strobe_outputs(aux_strobe_outputs),
    .extra_m_strobe_outputs(extra_m_strobe_outputs), .aux_finish_inputs(aux_finish_inputs),
    .aux_fast_finish_inputs(aux_fast_finish_inputs));
  // ==========================================================
  // Expectations and helpers
  function automatic logic [2:0] exp_mode(input logic [7:0] b);
    if (b[auto_start_pkg::MODE_HI:0] == auto_start_pkg::MODE_MANUAL_ENTRY)
      return 3'h3;
    if (b[auto_start_pkg::MODE_HI:0] == auto_start_pkg::MODE_MEMORY)
      return b[auto_start_pkg::REMOTE_BIT] ? 3'h2 : 3'h1;
    return 3'h0;
  endfunction
  function automatic logic [15:0] exp_pct(input logic [7:0] a, input logic [7:0] b, input logic fit);
    logic [15:0] x;
    logic [15:0] y;
    x = (a == auto_start_pkg::OVERRIDE_ZERO) ? 16'h0000 : {8'h00, ~a};
    y = (b == auto_start_pkg::OVERRIDE_ZERO) ? 16'h0000 : {8'h00, ~b};
    return fit ? (x * y) / 16'h0064 : x;
  endfunction
  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask
  task automatic results;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_adv(input int n, output bit seen);
    seen = 0;
    repeat (n)
    begin
      @(posedge sys_clk);
      #1 seen = seen | (block_advance === 1'b1);
    end
  endtask
  task automatic try_start(input logic [7:0] m, input logic [7:0] h, input logic lk, input bit rel, input logic ex);
    @(posedge sys_clk);
    mode_select_input <= m;
    feed_hold_input <= h;
    cycle_start_input <= {5'h00, 1'b1, lk, 1'b0};
    repeat (4) @(posedge sys_clk);
    if (rel)
      cycle_start_input <= {5'h00, 1'b0, lk, 1'b0};
    repeat (8) @(posedge sys_clk);
    #1 check(auto_running === ex, "cycle start outcome");
    @(posedge sys_clk);
    mode_select_input <= 8'h02;
    repeat (4) @(posedge sys_clk);
    cycle_start_input <= 8'h00;
    feed_hold_input <= 8'h20;
  endtask
  task automatic do_req(input int fn, input int pos, input bit ext, input bit go);
    logic [7:0] old;
    @(posedge sys_clk);
    #1 old = ext ? extra_m_strobe_outputs : aux_strobe_outputs;
    @(posedge sys_clk) func_request <= 6'h01 << fn;
    @(posedge sys_clk) func_request <= 6'h00;
    wait_adv(40, adv);
    check(((ext ? extra_m_strobe_outputs : aux_strobe_outputs) ^ old) === (go ? 8'h01 << pos : 8'h00), "strobe");
    check(adv === go, "block advance after finish");
  endtask
  // ==========================================================
  // Tests
  initial
  begin
    #200us;
    n_fail++;
    results();
  end
  initial
  begin
    void'($urandom(32'hd30c338d));
    repeat (11) @(posedge sys_clk);
    #1 check({auto_running, block_advance, aux_strobe_outputs, feed_scale_pct, sequencer_diag_view} === '0, "reset");
    @(posedge sys_clk) sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    foreach (modes[i])
    begin
      @(posedge sys_clk) mode_select_input <= modes[i];
      repeat (5) @(posedge sys_clk);
      #1 check(mode_decoded === exp_mode(modes[i]), "mode decode");
    end
    $display("test mode done");
    try_start(8'h02, 8'h20, 1'b0, 1, 1'b0);
    try_start(8'h01, 8'h20, 1'b1, 1, 1'b0);
    try_start(8'h01, 8'h00, 1'b0, 1, 1'b0);
    try_start(8'h01, 8'h20, 1'b0, 0, 1'b0);
    try_start(8'h21, 8'h20, 1'b0, 1, 1'b1);
    @(posedge sys_clk) feed_hold_input <= 8'h00;
    repeat (6) @(posedge sys_clk);
    #1 check(auto_running === 1'b0 && feed_hold_active === 1'b1, "feed hold");
    @(posedge sys_clk) feed_hold_input <= 8'h20;
    try_start(8'h00, 8'h20, 1'b0, 1, 1'b1);
    $display("test start done");
    for (int t = 0; t < 2; t++)
    begin
      @(posedge sys_clk) turning_variant <= t[0];
      for (int k = 0; k < 4; k++)
      begin
        @(posedge sys_clk) lag <= 4'($urandom_range(0, 3));
        do_req(k, (k == 0) ? 0 : (k == 3) ? (t ? 4 : 7) : k + 1, 0, 1);
      end
    end
    do_req(4, 4, 1, 0);
    @(posedge sys_clk) multi_misc_config <= 8'h80;
    do_req(4, 4, 1, 1);
    do_req(5, 5, 1, 1);
    @(posedge sys_clk) aux_interface_config <= 8'h00;
    @(posedge sys_clk) func_request <= 6'h02;
    @(posedge sys_clk) func_request <= 6'h00;
    wait_adv(40, adv);
    check(adv === 1'b1, "normal finish advance");
    $display("test handshake done");
    @(posedge sys_clk) position_error <= 16'h0100;
    @(posedge sys_clk) positioning_done <= 1'b1;
    @(posedge sys_clk) positioning_done <= 1'b0;
    wait_adv(8, adv);
    check(adv === 1'b0 && sequencer_diag_view[auto_start_pkg::WAIT_INPOS] === 1'b1, "in-position wait");
    @(posedge sys_clk) position_error <= 16'h0005;
    wait_adv(20, adv);
    check(adv === 1'b1, "in-position release");
    @(posedge sys_clk) other_wait_status <= 16'($urandom);
    repeat (3) @(posedge sys_clk);
    #1 check((sequencer_diag_view & 16'hffc6) === (other_wait_status & 16'hffc6), "wait flags");
    $display("test wait done");
    for (int i = 0; i < 12; i++)
    begin
      p = (i < 4) ? modes[0] | {8{i != 3}} & ((i == 1) ? 8'h9b : (i == 2) ? 8'h01 : 8'hff) : 8'($urandom);
      f = 8'($urandom);
      @(posedge sys_clk);
      feed_override_primary <= p;
      feed_override_fine <= f;
      fine_override_fitted <= (i >= 4) && i[0];
      repeat (5) @(posedge sys_clk);
      #1 check(feed_scale_pct === exp_pct(p, f, fine_override_fitted), "override");
    end
    $display("test override done");
    results();
  end
endmodule // tb_auto_cycle_start
